//--- pkg/airq_pkg.sv
// airq_pkg: register map, field layout and reset values of the interrupt block
package airq_pkg;
  // ------------------------------------------------------------
  // register indices (printed offsets) and the apb address width
  // ------------------------------------------------------------
  localparam logic [7:0] AIRQ_IDX_STAT1 = 8'h07;
  localparam logic [7:0] AIRQ_IDX_STAT2 = 8'h08;
  localparam logic [7:0] AIRQ_IDX_G1_MASK = 8'h09;
  localparam logic [7:0] AIRQ_IDX_G1_MODE_UPPER = 8'h0a;
  localparam logic [7:0] AIRQ_IDX_G1_MODE_LOWER = 8'h0b;
  localparam logic [7:0] AIRQ_IDX_G2_MASK = 8'h0c;
  localparam logic [7:0] AIRQ_IDX_G2_MODE_UPPER = 8'h0d;
  localparam logic [7:0] AIRQ_IDX_G2_MODE_LOWER = 8'h0e;
  localparam int AIRQ_ADDR_W = 10;
  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam int AIRQ_G1_W = 8;
  localparam int AIRQ_G2_W = 6;
  localparam logic [7:0] AIRQ_REG_RESET = 8'h00;
  localparam logic [1:0] AIRQ_MODE_RISE = 2'h0;
  localparam logic [1:0] AIRQ_MODE_FALL = 2'h1;
  localparam logic [1:0] AIRQ_MODE_LEVEL = 2'h2;
  localparam logic [31:0] AIRQ_RD_ZERO = 32'h0000_0000;
endpackage

//--- src/airq_group.sv
// airq_group: a row of source cells sharing one status register
`timescale 1ns/10ps
`default_nettype none
module airq_group
  import airq_pkg::*;
#(
  parameter int W = 8
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sources and controls
  input wire logic [W-1:0] cond,
  input wire logic [W-1:0] mask,
  input wire logic [W-1:0] mode_upper,
  input wire logic [W-1:0] mode_lower,
  input wire logic rd_clear,
  // status
  output logic [W-1:0] status
);
  for (genvar i = 0; i < W; i++) begin : g_cell
    airq_src_cell u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .cond(cond[i]),
      .mask(mask[i]),
      .mode({mode_upper[i], mode_lower[i]}), // [RQ7] [RQ8]
      .rd_clear(rd_clear),
      .status(status[i])
    );
  end
endmodule
`default_nettype wire

//--- src/airq_src_cell.sv
// airq_src_cell: trigger detection and sticky status for one interrupt source
`timescale 1ns/10ps
`default_nettype none
module airq_src_cell
  import airq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // source and controls
  input wire logic cond,
  input wire logic mask,
  input wire logic [1:0] mode,
  input wire logic rd_clear,
  // result
  output logic status
);
  typedef struct packed {
    logic cond_d;
    logic stat;
  } airq_cell_t;
  airq_cell_t st, next_st;
  logic trig;

  // ------------------------------------------------------------
  // trigger decode
  // ------------------------------------------------------------
  always_comb begin
    unique case (mode)
      AIRQ_MODE_RISE: trig = cond & ~st.cond_d; // [RQ9] [RQ10]
      AIRQ_MODE_FALL: trig = ~cond & st.cond_d; // [RQ9] [RQ10]
      AIRQ_MODE_LEVEL: trig = cond; // [RQ9] [RQ10]
      // reserved code is treated like rising edge
      default: trig = cond & ~st.cond_d;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.cond_d = cond;
    // set wins over the read clear; masked sources never set
    if (!mask) begin
      next_st.stat = 1'b0; // [RQ5] [RQ15]
    end else if (trig) begin
      next_st.stat = 1'b1; // [RQ4] [RQ13] [RQ14]
    end else if (rd_clear) begin
      next_st.stat = 1'b0; // [RQ14]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign status = st.stat;

  a_masked_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !mask |=> !st.stat) else $error("masked source set its status"); // [RQ5]
endmodule
`default_nettype wire

//--- src/airq_top.sv
// airq_top: interrupt mask, trigger mode and status logic with an apb register port
//
// Summary of operation
// RQ1: q_subcode_block_ready source flags each new Q-subcode block for the host.
// RQ2: host reads the Q-subcode block within 588 frames of the interrupt.
// RQ3: group 1 mask at 09h, one bit per source, aligned with status bits.
// RQ4: mask bit 1 lets the source set status and drive the interrupt.
// RQ5: mask bit 0 ignores the source for status and interrupt.
// RQ6: mask registers reset to zero, all sources masked.
// RQ7: group 1 mode code: 0Ah gives upper bit, 0Bh lower bit.
// RQ8: group 2 mode code: 0Dh upper, 0Eh lower, bits 5 to 0.
// RQ9: code 00 rising, 01 falling, 10 level, 11 reserved.
// RQ10: mode picks activation on arrival, removal or persistence of a condition.
// RQ11: mode registers reset to zero, rising edge for every source.
// RQ12: group 2 mask at 0Ch holds bits 5 to 0; bits 7,6 read zero.
// RQ13: status bits are sticky until the host reads the register.
// RQ14: reading status clears it except level sources still asserted.
// RQ15: masked status bits always read as zero.
// RQ16: interrupt pin high while any unmasked status bit is set.
// RQ17: host avoids reserved mode code 11; device treats it as rising edge.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module airq_top
  import airq_pkg::*;
#(
  parameter int G1_W = AIRQ_G1_W,
  parameter int G2_W = AIRQ_G2_W
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AIRQ_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // group 1 sources: bit 7 tx_sample_slip .. bit 0 receiver_fault
  input wire logic [G1_W-1:0] group1_cond,
  // group 2 sources: bit 1 is q_subcode_block_ready
  input wire logic [G2_W-1:0] group2_cond,
  // interrupt pin
  output logic irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] g1_mask;
    logic [7:0] g1_mode_upper;
    logic [7:0] g1_mode_lower;
    logic [7:0] g2_mask;
    logic [7:0] g2_mode_upper;
    logic [7:0] g2_mode_lower;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
    logic rd1;
    logic rd2;
  } airq_top_t;
  airq_top_t st, next_st;

  logic [G1_W-1:0] stat1;
  logic [G2_W-1:0] stat2;
  logic [7:0] stat1_b, stat2_b;
  logic setup, access;
  logic [7:0] idx;
  logic idx_ok;

  assign setup = psel & ~penable;
  assign access = psel & penable & st.ready;
  assign idx = 8'(paddr[AIRQ_ADDR_W-1:2]);
  // gate with the live mask so a bit whose mask was just cleared never shows
  assign stat1_b = 8'(stat1 & st.g1_mask[G1_W-1:0]); // [RQ15]
  assign stat2_b = 8'(stat2 & st.g2_mask[G2_W-1:0]); // [RQ15]
  assign idx_ok = (paddr[1:0] == 2'h0) &&
    (idx >= AIRQ_IDX_STAT1) && (idx <= AIRQ_IDX_G2_MODE_LOWER);

  // ------------------------------------------------------------
  // source groups
  // ------------------------------------------------------------
  // the q subcode ready line is one of the group 2 conditions [RQ1]
  airq_group #(.W(G1_W)) u_g1 (
    .pclk(pclk),
    .presetn(presetn),
    .cond(group1_cond),
    .mask(st.g1_mask[G1_W-1:0]), // [RQ3]
    .mode_upper(st.g1_mode_upper[G1_W-1:0]), // [RQ7]
    .mode_lower(st.g1_mode_lower[G1_W-1:0]), // [RQ7]
    .rd_clear(st.rd1),
    .status(stat1)
  );
  airq_group #(.W(G2_W)) u_g2 (
    .pclk(pclk),
    .presetn(presetn),
    .cond(group2_cond),
    .mask(st.g2_mask[G2_W-1:0]), // [RQ12]
    .mode_upper(st.g2_mode_upper[G2_W-1:0]), // [RQ8]
    .mode_lower(st.g2_mode_lower[G2_W-1:0]), // [RQ8]
    .rd_clear(st.rd2),
    .status(stat2)
  );

  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------
  // no wait state: ready rises the cycle after setup, so the read
  // data lines up with the access edge and the read-clear pulse follows it
  always_comb begin
    next_st = st;
    next_st.ready = setup;
    next_st.slverr = setup & ~idx_ok;
    next_st.rd1 = 1'b0;
    next_st.rd2 = 1'b0;
    if (setup && !pwrite) begin
      unique case (idx)
        AIRQ_IDX_STAT1: next_st.rdata = {24'h000000, stat1_b};
        AIRQ_IDX_STAT2: next_st.rdata = {24'h000000, stat2_b};
        AIRQ_IDX_G1_MASK: next_st.rdata = {24'h000000, st.g1_mask};
        AIRQ_IDX_G1_MODE_UPPER: next_st.rdata = {24'h000000, st.g1_mode_upper};
        AIRQ_IDX_G1_MODE_LOWER: next_st.rdata = {24'h000000, st.g1_mode_lower};
        AIRQ_IDX_G2_MASK: next_st.rdata = {24'h000000, st.g2_mask}; // [RQ12]
        AIRQ_IDX_G2_MODE_UPPER: next_st.rdata = {24'h000000, st.g2_mode_upper};
        AIRQ_IDX_G2_MODE_LOWER: next_st.rdata = {24'h000000, st.g2_mode_lower};
        default: next_st.rdata = AIRQ_RD_ZERO;
      endcase
    end
    if (access && !pwrite && idx_ok) begin
      // clear follows the access edge; an event in that cycle still sets
      next_st.rd1 = (idx == AIRQ_IDX_STAT1); // [RQ14]
      next_st.rd2 = (idx == AIRQ_IDX_STAT2); // [RQ14]
    end
    if (access && pwrite && idx_ok) begin
      unique case (idx)
        AIRQ_IDX_G1_MASK: next_st.g1_mask = pwdata[7:0]; // [RQ3]
        AIRQ_IDX_G1_MODE_UPPER: next_st.g1_mode_upper = pwdata[7:0];
        AIRQ_IDX_G1_MODE_LOWER: next_st.g1_mode_lower = pwdata[7:0];
        AIRQ_IDX_G2_MASK: next_st.g2_mask = {2'h0, pwdata[5:0]}; // [RQ12]
        AIRQ_IDX_G2_MODE_UPPER: next_st.g2_mode_upper = {2'h0, pwdata[5:0]};
        AIRQ_IDX_G2_MODE_LOWER: next_st.g2_mode_lower = {2'h0, pwdata[5:0]};
        default: next_st.g1_mask = st.g1_mask;
      endcase
    end
    // masked bits are gated here too, so the pin drops with the mask
    next_st.irq = (|stat1_b) | (|stat2_b); // [RQ16]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.g1_mask <= AIRQ_REG_RESET; // [RQ6]
      st.g2_mask <= AIRQ_REG_RESET; // [RQ6]
      st.g1_mode_upper <= AIRQ_REG_RESET; // [RQ11]
      st.g1_mode_lower <= AIRQ_REG_RESET; // [RQ11]
      st.g2_mode_upper <= AIRQ_REG_RESET; // [RQ11]
      st.g2_mode_lower <= AIRQ_REG_RESET; // [RQ11]
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.slverr;
  assign irq = st.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_status1_read;
    access && !pwrite && idx == AIRQ_IDX_STAT1;
  endsequence

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    ((|stat1_b) || (|stat2_b)) |=> irq) else $error("irq missed a set status"); // [RQ16]
  a_irq_release: assert property (@(posedge pclk) disable iff (!presetn)
    (!(|stat1_b) && !(|stat2_b)) |=> !irq) else $error("irq stuck high"); // [RQ16]
  a_g2_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    st.g2_mask[7:6] == 2'h0) else $error("group 2 mask upper bits set"); // [RQ12]
  a_mask1_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ((stat1 & ~$past(st.g1_mask[G1_W-1:0])) == '0)) else $error("masked status seen"); // [RQ15]
  a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    s_status1_read ##0 (group1_cond == '0) ##1 (group1_cond == '0) |=>
      (stat1 == '0))
    else $error("status not cleared by read"); // [RQ14]
  a_level_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (st.g1_mask[0] && st.g1_mode_upper[0] && !st.g1_mode_lower[0] && group1_cond[0])
      |=> stat1[0]) else $error("level source lost its status"); // [RQ9]
  a_rise_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (st.g2_mask[1] && st.g2_mode_upper[1:1] == 1'b0 && st.g2_mode_lower[1:1] == 1'b0
      && group2_cond[1] && !$past(group2_cond[1])) |=> stat2[1])
    else $error("q subcode ready not flagged"); // [RQ1]
  a_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready) else $error("no answer one cycle after setup");

  // ------------------------------------------------------------
  // further checks on register writes, status and the pin
  // ------------------------------------------------------------
  // building blocks shared by the checks below
  sequence s_status2_read;
    access && !pwrite && idx == AIRQ_IDX_STAT2;
  endsequence

  sequence s_write_hit;
    access && pwrite && idx_ok;
  endsequence

  sequence s_g1_quiet;
    group1_cond == '0;
  endsequence

  sequence s_g2_quiet;
    group2_cond == '0;
  endsequence

  sequence s_bad_setup;
    setup && !idx_ok;
  endsequence

  // a status 2 read with quiet sources leaves nothing set
  a_read_clears2: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
    s_status2_read ##0 s_g2_quiet ##1 s_g2_quiet |=>
      (stat2 == '0))
    else $error("status 2 not cleared by read");

  // the cells clear one edge after the mask falls
  a_mask2_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
    ((stat2 & ~$past(st.g2_mask[G2_W-1:0])) == '0))
    else $error("masked status 2 seen");

  // mask writes land at the access edge
  a_mask1_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
    s_write_hit ##0 (idx == AIRQ_IDX_G1_MASK) |=>
      (st.g1_mask == $past(pwdata[7:0])))
    else $error("group 1 mask write lost");

  // only the six defined bits are kept
  a_mask2_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
    s_write_hit ##0 (idx == AIRQ_IDX_G2_MASK) |=>
      (st.g2_mask == {2'h0, $past(pwdata[5:0])}))
    else $error("group 2 mask write lost");

  a_mode1_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
    s_write_hit ##0 (idx == AIRQ_IDX_G1_MODE_LOWER) |=>
      (st.g1_mode_lower == $past(pwdata[7:0])))
    else $error("group 1 mode write lost");

  a_mode2_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
    s_write_hit ##0 (idx == AIRQ_IDX_G2_MODE_UPPER) |=>
      (st.g2_mode_upper == {2'h0, $past(pwdata[5:0])}))
    else $error("group 2 mode write lost");

  // unused group 2 mode bits stay zero
  a_g2_mode_top: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
    (st.g2_mode_upper[7:6] == 2'h0) && (st.g2_mode_lower[7:6] == 2'h0))
    else $error("group 2 mode upper bits set");

  // every register is one byte wide
  a_rdata_upper: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
    pready |-> (prdata[31:8] == 24'h000000))
    else $error("read data upper bits set");

  // an unmapped address is answered with an error, not ignored
  a_err_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
    s_bad_setup |=> (pready && pslverr))
    else $error("bad address not flagged");

  // the answer stands exactly one cycle
  a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");

  // falling edge mode on group 1 bit 0
  a_fall_sets: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
    (st.g1_mask[0] && !st.g1_mode_upper[0] && st.g1_mode_lower[0]
      && !group1_cond[0] && $past(group1_cond[0])) |=> stat1[0])
    else $error("falling edge not flagged");

  // rising edge mode on group 1 bit 7
  a_rise1_top: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
    (st.g1_mask[7] && !st.g1_mode_upper[7] && !st.g1_mode_lower[7]
      && group1_cond[7] && !$past(group1_cond[7])) |=> stat1[7])
    else $error("rising edge not flagged");

  // level mode keeps flagging while the condition persists
  a_level2_holds: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
    (st.g2_mask[1] && st.g2_mode_upper[1] && !st.g2_mode_lower[1]
      && group2_cond[1]) |=> stat2[1])
    else $error("level source 2 lost its status");

  // without a read a set bit stays set
  a_sticky1: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
    (stat1[0] && st.g1_mask[0] && !st.rd1) |=> stat1[0])
    else $error("status 1 bit dropped without read");

  a_sticky2: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
    (stat2[1] && st.g2_mask[1] && !st.rd2) |=> stat2[1])
    else $error("status 2 bit dropped without read");

  // with every source masked the pin stays low
  a_masked_no_irq: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
    (st.g1_mask == 8'h00 && st.g2_mask == 8'h00) |=> !irq)
    else $error("irq raised with all sources masked");

  // a clear pulse only follows a completed read
  a_idle_no_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
    !access |=> (!st.rd1 && !st.rd2))
    else $error("status cleared without a read");
endmodule
`default_nettype wire

//--- tb/airq_host.sv
// airq_host: apb master standing in for the host controller
`timescale 1ns/10ps
`default_nettype none
module airq_host
  import airq_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [AIRQ_ADDR_W-1:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0000_0000;
  end
  // released lines show the inverse, so a stale value cannot pass for a fresh one
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~{idx, 2'b00};
    pwdata <= ~wd;
  endtask
endmodule
`default_nettype wire

//--- tb/airq_top_tb.sv
// airq_top_tb: self-checking bench for the interrupt mask and mode block
`timescale 1ns/10ps
`default_nettype none
module airq_top_tb
  import airq_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [AIRQ_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] g1c;
  logic [5:0] g2c;
  logic [15:0] seed;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;

  airq_host host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  airq_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .group1_cond(g1c), .group2_cond(g2c), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // about 660 cycles are needed; the ceiling leaves ample margin
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] ex(input logic c, input logic [7:0] v);
    return c ? {24'h000000, v} : 32'h0000_0000;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    host.xfer(1'b1, i, d, rd, err);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [31:0] e);
    host.xfer(1'b0, i, 32'h0000_0000, rd, err);
    chk("rdata", e, rd);
  endtask
  task automatic drv(input logic g, input int b, input logic v);
    @(posedge pclk);
    if (g)
      g2c[b] <= v;
    else
      g1c[b] <= v;
  endtask
  // one source through a full raise, hold and drop; mk low means masked
  task automatic trig(input logic g, input int b, input logic [1:0] m, input logic mk);
    logic [7:0] v, st;
    v = mk ? (8'h01 << b) : 8'h00;
    st = g ? AIRQ_IDX_STAT2 : AIRQ_IDX_STAT1;
    wr(g ? AIRQ_IDX_G2_MASK : AIRQ_IDX_G1_MASK, {24'h0, v});
    wr(g ? AIRQ_IDX_G2_MODE_UPPER : AIRQ_IDX_G1_MODE_UPPER, {24'h0, m[1] ? 8'h01 << b : 8'h00});
    wr(g ? AIRQ_IDX_G2_MODE_LOWER : AIRQ_IDX_G1_MODE_LOWER, {24'h0, m[0] ? 8'h01 << b : 8'h00});
    host.xfer(1'b0, st, 32'h0000_0000, rd, err);
    drv(g, b, 1'b1);
    repeat (3) @(posedge pclk);
    chk("irq", {31'h0, |ex(m != AIRQ_MODE_FALL, v)}, {31'h0, irq});
    rdc(st, ex(m != AIRQ_MODE_FALL, v));
    repeat (3) @(posedge pclk);
    rdc(st, ex(m == AIRQ_MODE_LEVEL, v));
    drv(g, b, 1'b0);
    repeat (3) @(posedge pclk);
    rdc(st, ex(m != AIRQ_MODE_RISE, v));
    rdc(st, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk("irq", 32'h0000_0000, {31'h0, irq});
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    g1c = 8'h00;
    g2c = 6'h00;
    seed = 16'h0043;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 7; i < 15; i++) rdc(i[7:0], 32'h0000_0000);
    for (int i = 9; i < 15; i++) begin
      seed = lfsr(seed);
      wr(i[7:0], {16'h0000, seed});
      rdc(i[7:0], {24'h0, seed[7:0] & (i > 11 ? 8'h3f : 8'hff)});
    end
    host.xfer(1'b0, 8'h05, 32'h0000_0000, rd, err);
    chk("slverr", 32'h0000_0001, {31'h0, err});
    // reserved code 11 is never the mode under test
    for (int k = 0; k < 15; k++) begin
      seed = lfsr(seed);
      trig(seed[0], seed[0] ? seed[3:1] % 6 : seed[3:1], k % 3, k < 12);
    end
    wr(AIRQ_IDX_G1_MODE_UPPER, 32'h0000_0000);
    wr(AIRQ_IDX_G1_MODE_LOWER, 32'h0000_0000);
    wr(AIRQ_IDX_G1_MASK, 32'h0000_0001);
    drv(1'b0, 0, 1'b1);
    repeat (3) @(posedge pclk);
    wr(AIRQ_IDX_G1_MASK, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    rdc(AIRQ_IDX_STAT1, 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire
